// File: verilog/dmbl_map.svh
// register offsets, field positions, codes and reset values of the mode-word block
// assumes inclusion by bare name from every design file that needs them
`ifndef DMBL_MAP_SVH
`define DMBL_MAP_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define DMBL_OFS_MW0   8'h00
`define DMBL_OFS_MW1   8'h04
`define DMBL_OFS_MW2   8'h08
`define DMBL_OFS_CTRL  8'h0c
`define DMBL_OFS_STAT  8'h10

// ---------------------------------------------------------------
// mode word fields, control and status bits, chop address pin and mode word reset value
// ---------------------------------------------------------------
`define DMBL_MW0_BLEN  1:0
`define DMBL_MW0_CLLO  2
`define DMBL_MW0_BTYPE 3
`define DMBL_MW0_CLHI  6:4
`define DMBL_MW0_TEST  7
`define DMBL_MW0_LRST  8
`define DMBL_MW1_LOOP  0
`define DMBL_MW1_ADD   4:3
`define DMBL_MW1_NOMT  10:8
`define DMBL_MW2_CWL   5:3
`define DMBL_MW2_STRT  11:9
`define DMBL_MW2_CRC   12
`define DMBL_CHOP_PIN  12
`define DMBL_CTL_MASK  0
`define DMBL_STAT_CKE  5
`define DMBL_RST_MW    14'h0000

// ---------------------------------------------------------------
// codes
// ---------------------------------------------------------------
`define DMBL_BL_FULL   2'h0
`define DMBL_BL_OTF    2'h1
`define DMBL_BL_CHOP   2'h2
`define DMBL_ADD_M1    2'h1
`define DMBL_ADD_M2    2'h2
`define DMBL_SEL_MW0   2'h0
`define DMBL_SEL_MW1   2'h1
`define DMBL_SEL_MW2   2'h2
`define DMBL_CMD_READ  3'h1
`define DMBL_CMD_WRITE 3'h2
`define DMBL_CMD_MRS   3'h3
`define DMBL_CMD_SREN  3'h4
`define DMBL_CMD_SREX  3'h5
`define DMBL_SLOT_CHOP 3'h3
`define DMBL_SLOT_FULL 3'h7
`define DMBL_BEAT_HALF 2

`endif

// File: verilog/dmbl_pkg.sv
// types shared by the mode-word block and its beat-order helper
// assumes nothing of its surroundings
package dmbl_pkg;
  typedef logic [13:0] dmbl_mw_t;
  typedef logic [2:0]  dmbl_beat_t;
  typedef logic [5:0]  dmbl_lat_t;
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_BURST} dmbl_rd_e;
  typedef enum logic [2:0] {WR_IDLE, WR_WAIT, WR_CAPT, WR_CHECK, WR_COMMIT} dmbl_wr_e;
endpackage : dmbl_pkg

// File: verilog/dmbl_ord_if.sv
// carries the burst start bits and the resulting beat order
// assumes the owner drives start and interleave from flip-flops
`timescale 1ns/100ps
interface dmbl_ord_if;
  import dmbl_pkg::*;
  dmbl_beat_t start;
  logic       interleave;
  dmbl_beat_t order [8];
  modport gen (input start, input interleave, output order);
  modport src (output start, output interleave, input order);
endinterface : dmbl_ord_if

// File: verilog/dmbl_beat_order.sv
// beat order table for one burst: low column bits of each of the eight beats
// assumes start and interleave are stable while a burst is running
`timescale 1ns/100ps
module dmbl_beat_order
  import dmbl_pkg::*;
(
  dmbl_ord_if.gen ord
);
  // ---------------------------------------------------------------
  // one order entry per beat
  // ---------------------------------------------------------------
  for (genvar b = 0; b < 8; b++) begin : g_beat
    localparam dmbl_beat_t BI = dmbl_beat_t'(b);
    // sequential wraps in the group of four, second group keeps the offset
    assign ord.order[b] = ord.interleave ? (ord.start ^ BI)
                        : {ord.start[2] ^ BI[2], ord.start[1:0] + BI[1:0]};
  end
endmodule : dmbl_beat_order

// File: verilog/dmbl_ctrl.sv
// mode words zero to two of a x16 sdram: latency, burst order, loop control, write checks
// assumes a plain register port on i_clk_sys and link pins from another clock domain
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "dmbl_map.svh"

module dmbl_ctrl
  import dmbl_pkg::*;
#(
  parameter int CL_BASE   = 9,
  parameter int CWL_BASE  = 9,
  parameter int LOCK_CLKS = 1024,
  parameter int COL_W     = 10
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  input  wire logic        i_lnk_ck,
  input  wire logic        i_lnk_cke,
  input  wire logic [2:0]  i_lnk_cmd,
  input  wire logic [13:0] i_lnk_addr,
  input  wire logic [1:0]  i_lnk_mw_sel,
  input  wire logic [15:0] i_lnk_dq,
  input  wire logic        i_lnk_crc_err,
  output logic      [15:0] o_lnk_dq,
  output logic             o_lnk_dq_oe,
  output logic             o_lnk_dqs,
  output logic             o_lnk_dqs_oe,
  output logic             o_term_wr_en,
  output logic [COL_W-1:0] o_arr_rd_col,
  input  wire logic [15:0] i_arr_rd_data,
  output logic             o_arr_wr_en,
  output logic [COL_W-1:0] o_arr_wr_col,
  output logic      [15:0] o_arr_wr_data,
  output logic             o_wr_recov_start
);
  localparam int LOCK_W = $clog2(LOCK_CLKS + 1);
  localparam int LNK_W  = 38;

  if (CL_BASE < 2 || CWL_BASE < 1 || LOCK_CLKS < 1 || COL_W < 4) begin : g_bad
    $error("dmbl_ctrl: parameter out of range");
  end

  // ---------------------------------------------------------------
  // link synchroniser and edge detect
  // ---------------------------------------------------------------
  logic [LNK_W-1:0] sync1_ff, sync2_ff;
  logic             ck_prev_ff;
  logic             s_ck, s_cke, s_crc;
  logic [2:0]       s_cmd;
  logic [13:0]      s_addr;
  logic [1:0]       s_sel;
  logic [15:0]      s_dq;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync1_ff   <= '0;
      sync2_ff   <= '0;
      ck_prev_ff <= 1'b0;
    end else begin
      sync1_ff   <= {i_lnk_ck, i_lnk_cke, i_lnk_cmd, i_lnk_addr, i_lnk_mw_sel, i_lnk_dq, i_lnk_crc_err};
      sync2_ff   <= sync1_ff;
      ck_prev_ff <= s_ck;
    end
  end
  assign {s_ck, s_cke, s_cmd, s_addr, s_sel, s_dq, s_crc} = sync2_ff;

  logic ck_rise, beat_edge, is_rd, is_wr, is_mrs;
  assign ck_rise   = s_ck & ~ck_prev_ff;
  assign beat_edge = s_ck ^ ck_prev_ff;
  assign is_rd     = ck_rise && s_cmd == `DMBL_CMD_READ;
  assign is_wr     = ck_rise && s_cmd == `DMBL_CMD_WRITE;
  assign is_mrs    = ck_rise && s_cmd == `DMBL_CMD_MRS;

  // ---------------------------------------------------------------
  // mode words and control register
  // ---------------------------------------------------------------
  dmbl_mw_t mw0_ff, mw1_ff, mw2_ff;
  logic     ctl_mask_ff, sw_wr0, sw_wr1, sw_wr2, mw0_set;
  assign sw_wr0  = i_reg_wr && i_reg_addr == `DMBL_OFS_MW0;
  assign sw_wr1  = i_reg_wr && i_reg_addr == `DMBL_OFS_MW1;
  assign sw_wr2  = i_reg_wr && i_reg_addr == `DMBL_OFS_MW2;
  assign mw0_set = sw_wr0 | (is_mrs && s_sel == `DMBL_SEL_MW0);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mw0_ff      <= `DMBL_RST_MW;
      mw1_ff      <= `DMBL_RST_MW;
      mw2_ff      <= `DMBL_RST_MW;
      ctl_mask_ff <= 1'b0;
    end else begin
      if (mw0_ff[`DMBL_MW0_LRST]) begin
        mw0_ff[`DMBL_MW0_LRST] <= 1'b0;
      end
      if (sw_wr0) mw0_ff <= dmbl_mw_t'(i_reg_wdata);
      if (sw_wr1) mw1_ff <= dmbl_mw_t'(i_reg_wdata);
      if (sw_wr2) mw2_ff <= dmbl_mw_t'(i_reg_wdata);
      if (is_mrs && s_sel == `DMBL_SEL_MW0) mw0_ff <= s_addr;
      if (is_mrs && s_sel == `DMBL_SEL_MW1) mw1_ff <= s_addr;
      if (is_mrs && s_sel == `DMBL_SEL_MW2) mw2_ff <= s_addr;
      if (i_reg_wr && i_reg_addr == `DMBL_OFS_CTRL) ctl_mask_ff <= i_reg_wdata[`DMBL_CTL_MASK];
    end
  end

  // ---------------------------------------------------------------
  // latency and burst length decode
  // ---------------------------------------------------------------
  dmbl_lat_t col_lat, add_dly, fetch_dly, store_dly;
  logic      chop_now, crc_chk;
  always_comb begin
    col_lat = dmbl_lat_t'(CL_BASE) + dmbl_lat_t'({mw0_ff[`DMBL_MW0_CLHI], mw0_ff[`DMBL_MW0_CLLO]});
    case (mw1_ff[`DMBL_MW1_ADD])
      `DMBL_ADD_M1: add_dly = col_lat - 6'h01;
      `DMBL_ADD_M2: add_dly = col_lat - 6'h02;
      default:      add_dly = '0;
    endcase
    fetch_dly = add_dly + col_lat;
    store_dly = add_dly + dmbl_lat_t'(CWL_BASE) + dmbl_lat_t'(mw2_ff[`DMBL_MW2_CWL]);
    case (mw0_ff[`DMBL_MW0_BLEN])
      `DMBL_BL_CHOP: chop_now = 1'b1;
      `DMBL_BL_OTF:  chop_now = ~s_addr[`DMBL_CHOP_PIN];
      default:       chop_now = 1'b0;
    endcase
  end
  assign crc_chk = ctl_mask_ff & mw2_ff[`DMBL_MW2_CRC];

  // ---------------------------------------------------------------
  // loop, self refresh and lock tracking
  // ---------------------------------------------------------------
  logic              sref_ff, locked_ff, cke_drop_ff, loop_on;
  logic [LOCK_W-1:0] lock_cnt_ff;
  assign loop_on = mw1_ff[`DMBL_MW1_LOOP] & ~sref_ff;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sref_ff <= 1'b0;
    end else if (ck_rise && s_cmd == `DMBL_CMD_SREN) begin
      sref_ff <= 1'b1;
    end else if (ck_rise && s_cmd == `DMBL_CMD_SREX) begin
      sref_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      lock_cnt_ff <= '0;
      locked_ff   <= 1'b0;
    end else if (mw0_ff[`DMBL_MW0_LRST]) begin
      lock_cnt_ff <= LOCK_W'(LOCK_CLKS);
      locked_ff   <= 1'b0;
    end else if (!mw1_ff[`DMBL_MW1_LOOP]) begin
      locked_ff   <= 1'b0;
    end else if (ck_rise && loop_on && lock_cnt_ff != '0) begin
      lock_cnt_ff <= lock_cnt_ff - LOCK_W'(1);
      if (lock_cnt_ff == LOCK_W'(1)) locked_ff <= 1'b1;
    end
  end

  // sticky: clock enable seen low during lock; set wins over a clear
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cke_drop_ff <= 1'b0;
    end else if (ck_rise && !s_cke && lock_cnt_ff != '0) begin
      cke_drop_ff <= 1'b1;
    end else if (i_reg_wr && i_reg_addr == `DMBL_OFS_STAT && i_reg_wdata[`DMBL_STAT_CKE]) begin
      cke_drop_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read burst
  // ---------------------------------------------------------------
  dmbl_ord_if ord_if ();
  dmbl_beat_order u_order (.ord(ord_if.gen));

  dmbl_rd_e         rd_st_ff;
  dmbl_lat_t        rd_cnt_ff, rd_lat_ff, rd_gap_ff;
  logic [COL_W-1:0] rd_col_ff;
  logic             rd_chop_ff, rd_ilv_ff, rd_emit;
  dmbl_beat_t       beat_ff, rd_ptr;
  assign ord_if.start      = rd_col_ff[2:0];
  assign ord_if.interleave = rd_ilv_ff;
  assign rd_emit = (rd_st_ff == RD_WAIT && ck_rise && rd_cnt_ff == 6'h01)
                 || (rd_st_ff == RD_BURST && beat_edge && beat_ff != '0);
  assign rd_ptr  = (rd_st_ff == RD_BURST) ? beat_ff : '0;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rd_st_ff <= RD_IDLE;
      rd_cnt_ff <= '0;
      rd_lat_ff <= '0;
      rd_gap_ff <= '0;
      rd_col_ff <= '0;
      rd_chop_ff <= 1'b0;
      rd_ilv_ff <= 1'b0;
      beat_ff <= '0;
    end else begin
      case (rd_st_ff)
        RD_IDLE: begin
          if (is_rd) begin
            rd_st_ff   <= RD_WAIT;
            rd_cnt_ff  <= fetch_dly;
            rd_lat_ff  <= fetch_dly;
            rd_gap_ff  <= '0;
            rd_col_ff  <= s_addr[COL_W-1:0];
            rd_chop_ff <= chop_now;
            rd_ilv_ff  <= mw0_ff[`DMBL_MW0_BTYPE];
          end
        end
        RD_WAIT: begin
          if (ck_rise) begin
            rd_gap_ff <= rd_gap_ff + 6'h01;
            rd_cnt_ff <= rd_cnt_ff - 6'h01;
            if (rd_emit) begin
              rd_st_ff <= RD_BURST;
              beat_ff  <= dmbl_beat_t'(1);
            end
          end
        end
        RD_BURST: begin
          if (beat_edge) begin
            beat_ff <= beat_ff + dmbl_beat_t'(1);
            if (beat_ff == '0) rd_st_ff <= RD_IDLE;
          end
        end
        default: rd_st_ff <= RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_arr_rd_col <= '0;
      o_lnk_dq     <= '0;
      o_lnk_dq_oe  <= 1'b0;
      o_lnk_dqs    <= 1'b0;
      o_lnk_dqs_oe <= 1'b0;
    end else begin
      o_arr_rd_col <= {rd_col_ff[COL_W-1:3], ord_if.order[rd_ptr]};
      if (rd_emit) begin
        o_lnk_dq     <= i_arr_rd_data;
        o_lnk_dq_oe  <= !(rd_chop_ff && rd_ptr[2]);
        o_lnk_dqs_oe <= !(rd_chop_ff && rd_ptr[2]);
        o_lnk_dqs    <= ~rd_ptr[0];
      end else if (rd_st_ff == RD_BURST && beat_edge) begin
        o_lnk_dq_oe  <= 1'b0;
        o_lnk_dqs_oe <= 1'b0;
        o_lnk_dqs    <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // write burst: capture, crc check, commit
  // ---------------------------------------------------------------
  dmbl_wr_e         wr_st_ff;
  dmbl_lat_t        wr_cnt_ff;
  logic [COL_W-1:0] wr_col_ff;
  logic             wr_chop_ff, wr_fix_ff, crc_bad_ff;
  dmbl_beat_t       slot_ff, wr_idx_ff, wr_last;
  logic [15:0]      wbuf [8];
  logic [7:0]       blocked_ff;
  assign wr_last = wr_fix_ff ? `DMBL_SLOT_CHOP : `DMBL_SLOT_FULL;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_st_ff <= WR_IDLE;
      wr_cnt_ff <= '0;
      wr_col_ff <= '0;
      wr_chop_ff <= 1'b0;
      wr_fix_ff <= 1'b0;
      crc_bad_ff <= 1'b0;
      slot_ff <= '0;
      wr_idx_ff <= '0;
      blocked_ff <= '0;
      o_arr_wr_en <= 1'b0;
      o_arr_wr_col <= '0;
      o_arr_wr_data <= '0;
      o_wr_recov_start <= 1'b0;
    end else begin
      o_arr_wr_en      <= 1'b0;
      o_wr_recov_start <= 1'b0;
      case (wr_st_ff)
        WR_IDLE: begin
          if (is_wr) begin
            wr_st_ff   <= WR_WAIT;
            wr_cnt_ff  <= store_dly;
            wr_col_ff  <= s_addr[COL_W-1:0];
            wr_chop_ff <= chop_now;
            wr_fix_ff  <= mw0_ff[`DMBL_MW0_BLEN] == `DMBL_BL_CHOP;
            slot_ff    <= '0;
          end
        end
        WR_WAIT: begin
          if (ck_rise) begin
            wr_cnt_ff <= wr_cnt_ff - 6'h01;
            if (wr_cnt_ff == 6'h01) wr_st_ff <= WR_CAPT;
          end
        end
        WR_CAPT: begin
          if (beat_edge || slot_ff == '0) begin
            wbuf[slot_ff] <= s_dq;
            slot_ff       <= slot_ff + dmbl_beat_t'(1);
            if (slot_ff == wr_last) begin
              wr_st_ff         <= WR_CHECK;
              crc_bad_ff       <= crc_chk & s_crc;
              o_wr_recov_start <= 1'b1;
            end
          end
        end
        WR_CHECK: begin
          wr_idx_ff <= '0;
          if (crc_bad_ff) begin
            wr_st_ff   <= WR_IDLE;
            blocked_ff <= blocked_ff + 8'h01;
          end else begin
            wr_st_ff <= WR_COMMIT;
          end
        end
        WR_COMMIT: begin
          o_arr_wr_en   <= 1'b1;
          o_arr_wr_data <= wbuf[wr_idx_ff];
          // low three start bits ignored, low two on chop; chop uses start bit 2 for the half
          o_arr_wr_col  <= wr_chop_ff ? {wr_col_ff[COL_W-1:2], wr_idx_ff[1:0]}
                                      : {wr_col_ff[COL_W-1:3], wr_idx_ff};
          wr_idx_ff     <= wr_idx_ff + dmbl_beat_t'(1);
          if (wr_idx_ff == (wr_chop_ff ? `DMBL_SLOT_CHOP : `DMBL_SLOT_FULL)) wr_st_ff <= WR_IDLE;
        end
        default: wr_st_ff <= WR_IDLE;
      endcase
    end
  end

  // termination on writes is only driven while the loop runs
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) o_term_wr_en <= 1'b0;
    else o_term_wr_en <= (wr_st_ff == WR_WAIT || wr_st_ff == WR_CAPT)
                         && mw2_ff[`DMBL_MW2_STRT] != '0 && loop_on;
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  logic [31:0] stat_w;
  assign stat_w = {16'h0000, blocked_ff, 2'h0, cke_drop_ff,
                   mw2_ff[`DMBL_MW2_STRT] != '0 && !loop_on,
                   mw0_ff[`DMBL_MW0_TEST], sref_ff, locked_ff, loop_on};

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_reg_rd) begin
      o_reg_rdata <= '0;
    end else begin
      case (i_reg_addr)
        `DMBL_OFS_MW0:  o_reg_rdata <= 32'(mw0_ff);
        `DMBL_OFS_MW1:  o_reg_rdata <= 32'(mw1_ff);
        `DMBL_OFS_MW2:  o_reg_rdata <= 32'(mw2_ff);
        `DMBL_OFS_CTRL: o_reg_rdata <= 32'(ctl_mask_ff);
        `DMBL_OFS_STAT: o_reg_rdata <= stat_w;
        default:        o_reg_rdata <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_no_store;
    !o_arr_wr_en [*3];
  endsequence
  sequence s_burst_go;
    rd_st_ff == RD_WAIT ##1 rd_st_ff == RD_BURST;
  endsequence

  a_lrst_self_clear: assert property (mw0_ff[`DMBL_MW0_LRST] && !mw0_set |=> !mw0_ff[`DMBL_MW0_LRST])
    else $error("loop reset bit did not clear");
  a_read_delay_ok: assert property (s_burst_go |-> rd_gap_ff == rd_lat_ff && o_lnk_dq_oe)
    else $error("first read beat at wrong delay");
  a_whole_clock_start: assert property (s_burst_go |-> $past(ck_rise))
    else $error("read burst started off a rising link edge");
  a_seq_order_ok: assert property (!rd_ilv_ff |-> ord_if.order[rd_ptr][1:0] == rd_col_ff[1:0] + rd_ptr[1:0]
                                   && ord_if.order[rd_ptr][2] == (rd_col_ff[2] ^ rd_ptr[2]))
    else $error("sequential beat order wrong");
  a_ilv_order_ok: assert property (rd_ilv_ff |-> ord_if.order[rd_ptr] == (rd_col_ff[2:0] ^ rd_ptr))
    else $error("interleaved beat order wrong");
  a_col_high_kept: assert property (rd_st_ff == RD_BURST |=> o_arr_rd_col[COL_W-1:3] == $past(rd_col_ff[COL_W-1:3]))
    else $error("high column bits altered");
  a_chop_hiz_tail: assert property (rd_st_ff == RD_BURST && rd_chop_ff && beat_ff > 3'h4 |-> !o_lnk_dq_oe && !o_lnk_dqs_oe)
    else $error("driver on in chopped tail");
  a_crc_block_drop: assert property (wr_st_ff == WR_CHECK && crc_bad_ff |=> wr_st_ff == WR_IDLE ##0 s_no_store)
    else $error("write committed despite crc error");
  a_fix_chop_early: assert property (o_wr_recov_start |-> slot_ff == ($past(wr_fix_ff) ? 3'h4 : 3'h0))
    else $error("write recovery start at wrong slot");
  a_store_data_pos: assert property (o_arr_wr_en && !wr_chop_ff |-> o_arr_wr_data == wbuf[o_arr_wr_col[2:0]])
    else $error("eight-beat write stored out of order");
  a_loop_sref_off: assert property (sref_ff |-> !loop_on ##0 (!o_term_wr_en [*2]))
    else $error("loop active in self refresh");
  a_term_needs_loop: assert property (o_term_wr_en |-> $past(loop_on))
    else $error("write termination without loop");
endmodule : dmbl_ctrl

// File: bench/dmbl_ctl_model.sv
// controller stand-in: link clock, commands, write beats, array read data
// assumes the bench calls send only while the device is idle
`timescale 1ns/100ps
module dmbl_ctl_model (
  output logic            o_ck,
  output logic [2:0]      o_cmd,
  output logic [13:0]     o_addr,
  output logic [15:0]     o_dq,
  input  wire logic [9:0] i_col,
  output logic [15:0]     o_rdat
);
  int rises = 0;
  initial begin
    o_ck   = 1'b0;
    o_cmd  = 3'h0;
    o_addr = 14'h0;
    o_dq   = 16'h0;
  end
  always #40 o_ck = ~o_ck;
  always @(posedge o_ck) rises++;
  // a fresh data beat on every link edge
  always @(o_ck) if ($time > 0) o_dq <= o_dq + 16'h1;
  assign o_rdat = {6'h0, i_col};
  task automatic send(input logic [2:0] c, input logic [13:0] a, output int r);
    @(negedge o_ck);
    o_cmd  = c;
    o_addr = a;
    @(posedge o_ck) #1 r = rises;
    @(negedge o_ck);
    o_cmd  = 3'h0;
    // released address lines do not keep the last value
    o_addr = ~a;
  endtask : send
endmodule : dmbl_ctl_model

// File: bench/test_dmbl_ctrl.sv
// bench for the mode-word block: register port, link reads and writes
// assumes the controller stand-in dmbl_ctl_model
`timescale 1ns/100ps
module test_dmbl_ctrl;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, crc = 0, tseen = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wd = 0, rdata, s;
  logic [15:0] dq, ard, odq, wdat;
  logic [13:0] la;
  logic [9:0]  rcol, wcol;
  logic [2:0]  cmd;
  logic        ck, dq_oe, dqs, dqs_oe, term, wen, recov;
  logic [15:0] q[$], wdq[$];
  logic [9:0]  wq[$];
  int          n_errors = 0, num_checks = 0, cyc = 0, r0, rf, r1;
  always #5 clk = ~clk;
  dmbl_ctl_model p (.o_ck(ck), .o_cmd(cmd), .o_addr(la), .o_dq(dq), .i_col(rcol), .o_rdat(ard));
  dmbl_ctrl #(.LOCK_CLKS(8)) uut (.i_clk_sys(clk), .i_rst(rst), .i_reg_addr(adr), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_lnk_ck(ck), .i_lnk_cke(1'b1), .i_lnk_cmd(cmd),
    .i_lnk_addr(la), .i_lnk_mw_sel(2'h0), .i_lnk_dq(dq), .i_lnk_crc_err(crc), .o_lnk_dq(odq),
    .o_lnk_dq_oe(dq_oe), .o_lnk_dqs(dqs), .o_lnk_dqs_oe(dqs_oe), .o_term_wr_en(term), .o_arr_rd_col(rcol),
    .i_arr_rd_data(ard), .o_arr_wr_en(wen), .o_arr_wr_col(wcol), .o_arr_wr_data(wdat),
    .o_wr_recov_start(recov));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dq_oe === 1'b1 && (q.size() == 0 || odq !== q[$])) begin
      check({dqs_oe, dqs}, {1'b1, q.size() % 2 == 0});
      q.push_back(odq);
    end
    if (wen === 1'b1) begin
      wq.push_back(wcol);
      wdq.push_back(wdat);
    end
    if (term === 1'b1) tseen <= 1'b1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    rd  <= 1'b1;
    adr <= a;
    @(posedge clk);
    rd  <= 1'b0;
    #1 s = rdata;
  endtask : rreg
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr  <= 1'b1;
    adr <= a;
    wd  <= d;
    @(posedge clk);
    wr  <= 1'b0;
  endtask : wreg
  task automatic mw0(input logic [13:0] v);
    p.send(3'h3, v, r0);
    repeat (6) @(posedge clk);
  endtask : mw0
  function automatic logic [2:0] bt(input logic [2:0] st, input logic [2:0] i, input logic il);
    return il ? st ^ i : {st[2] ^ i[2], st[1:0] + i[1:0]};
  endfunction : bt
  task automatic rdb(input logic [13:0] m0, input logic [13:0] m1, input logic [13:0] a, input int lat, input int n);
    mw0(m0);
    wreg(8'h04, {18'h0, m1});
    q.delete();
    p.send(3'h1, a, r0);
    for (int i = 0; i < 2000 && dq_oe !== 1'b1; i++) @(posedge clk) #1;
    check(p.rises - r0, lat);
    repeat (80) @(posedge clk);
    check(q.size(), n);
    foreach (q[i]) check(q[i], {6'h0, a[9:3], bt(a[2:0], i[2:0], m0[3])});
  endtask : rdb
  task automatic wrb(input logic [13:0] m0, input logic [13:0] a, input logic c, input int n,
                     input logic [2:0] lo, output int rr);
    mw0(m0);
    crc <= c;
    wq.delete();
    wdq.delete();
    p.send(3'h2, a, r0);
    for (int i = 0; i < 2000 && recov !== 1'b1; i++) @(posedge clk) #1;
    rr = p.rises - r0;
    repeat (30) @(posedge clk);
    check(wq.size(), n);
    foreach (wq[i]) check(wq[i], {a[9:3], lo + i[2:0]});
    foreach (wdq[i]) check(wdq[i] - wdq[0], i);
  endtask : wrb
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // mapped words read zero after reset, 0x14 is unmapped
    for (int i = 0; i < 6; i++) begin
      rreg(8'(i * 4));
      check(s, 32'h0);
    end
    wreg(8'h14, 32'hffffffff);
    rreg(8'h14);
    check(s, 32'h0);
    wreg(8'h08, 32'hffffffff);
    rreg(8'h08);
    check(s, 32'h3fff);
    wreg(8'h08, 32'h0);
    wreg(8'h04, 32'h1);
    mw0(14'h2b00);
    rreg(8'h00);
    check(s, 32'h2a00);
    repeat (12) @(posedge ck);
    rreg(8'h10);
    check(s[5:0], 6'h03);
    rdb(14'h0000, 14'h0001, 14'h12a5, 9, 8);
    rdb(14'h000c, 14'h0009, 14'h11fb, 19, 8);
    rdb(14'h0012, 14'h0011, 14'h1306, 20, 4);
    rdb(14'h0001, 14'h0001, 14'h00f7, 9, 4);
    rdb(14'h0009, 14'h0001, 14'h10f7, 9, 8);
    wrb(14'h0002, 14'h11f5, 1'b0, 4, 3'h4, rf);
    wrb(14'h0001, 14'h01f5, 1'b0, 4, 3'h4, r1);
    check(r1 - rf, 2);
    wreg(8'h0c, 32'h1);
    wreg(8'h08, 32'h1200);
    tseen <= 1'b0;
    wrb(14'h0000, 14'h12a5, 1'b1, 0, 3'h0, r1);
    check(tseen, 1'b1);
    rreg(8'h10);
    check(s[15:8], 8'h1);
    wrb(14'h0000, 14'h12a5, 1'b0, 8, 3'h0, r1);
    p.send(3'h4, 14'h0, r0);
    repeat (6) @(posedge clk);
    rreg(8'h10);
    check(s[2:0], 3'h6);
    p.send(3'h5, 14'h0, r0);
    repeat (6) @(posedge clk);
    rreg(8'h10);
    check(s[2:0], 3'h3);
    end_sim();
  end
endmodule : test_dmbl_ctrl
